// *** inc/bax_consts.vh ***
`ifndef BAX_CONSTS_VH
`define BAX_CONSTS_VH

// Operation select codes
`define BAX_OP_W            3
`define BAX_OP_NONE         3'h0
`define BAX_OP_ADD          3'h1
`define BAX_OP_ADDC         3'h2
`define BAX_OP_ASR          3'h3
`define BAX_OP_BCLR         3'h4
`define BAX_OP_TSKIP        3'h5
`define BAX_OP_RJMP         3'h6

// Widths
`define BAX_DATA_W          8
`define BAX_ADDR_W          7
`define BAX_PC_W            15
`define BAX_OFS_W           9
`define BAX_BIT_W           3

// Target select values
`define BAX_TGT_ACC         1'b0
`define BAX_TGT_REG         1'b1

// Field positions
`define BAX_MSB             7
`define BAX_NIB_MSB         3

// Reset values
`define BAX_ACC_RST         8'h00
`define BAX_PC_RST          15'h0000

`endif

// *** hw/bax_adder.v ***
`timescale 1ns/10ps
`include "bax_consts.vh"

module bax_adder (
    // Operands
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       cin,
    // Result
    output wire [7:0] sum,
    output wire       cout,
    output wire       nib_cout
);

    wire [4:0] low;
    wire [4:0] high;

    assign low      = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign high     = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low[4]};
    assign sum      = {high[3:0], low[3:0]};
    assign cout     = high[4];
    assign nib_cout = low[4];

endmodule

// *** hw/bax_exec.v ***
`timescale 1ns/10ps
`include "bax_consts.vh"

// Overview of operation
// - Add accumulator and addressed register, update flags
// - Target select 0 accumulator, 1 register
// - Add-with-carry includes current overflow bit
// - Shift right keeps bit 7, bit0 to overflow
// - Shift updates only overflow and nil flags
// - Clear chosen bit, others kept, no flags
// - Zero tested bit skips next as NOP
// - Jump to PC plus one plus offset
// - Relative jump always takes two cycles
module bax_exec (
    // Clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // Instruction issue
    input  wire        issue,
    input  wire [2:0]  op,
    input  wire [6:0]  reg_addr,
    input  wire        target_sel,
    input  wire [2:0]  bit_pos,
    input  wire [8:0]  offset,
    // Register file read data for reg_addr
    input  wire [7:0]  reg_rdata,
    // Register file write-back
    output reg         reg_we,
    output reg  [6:0]  reg_waddr,
    output reg  [7:0]  reg_wdata,
    // Architectural state
    output reg  [7:0]  acc,
    output reg         arith_ovf,
    output reg         nibble_carry,
    output reg         result_nil,
    output reg  [14:0] pc,
    // Pipeline control
    output wire        busy,
    output reg         flush
);

    localparam ST_RUN   = 1'b0;
    localparam ST_NOP   = 1'b1;

    reg         state;
    reg         next_state;
    reg  [7:0]  next_result;
    reg         next_write;
    reg         next_flags_add;
    reg         next_flags_shift;
    reg         next_second;
    reg  [14:0] next_pc;
    reg         next_to_reg;
    reg  [7:0]  next_acc;
    reg         next_ovf;
    reg         next_nib;
    reg         next_nil;
    reg         next_we;
    reg  [6:0]  next_waddr;
    reg  [7:0]  next_wdata;
    reg         next_flush;
    reg  [14:0] next_pc_commit;

    wire [7:0]  sum;
    wire        sum_cout;
    wire        sum_nib;
    wire        carry_in;
    wire [14:0] pc_inc;
    wire [14:0] ofs_ext;
    wire        take;
    wire        res_zero;
    wire [7:0]  shift_res;
    wire [7:0]  clr_res;

    // Carry participates only for add-with-carry
    // overflow bit in
    assign carry_in = (op == `BAX_OP_ADDC) ? arith_ovf : 1'b0;

    bax_adder u_adder (
        .a        (acc),
        .b        (reg_rdata),
        .cin      (carry_in),
        .sum      (sum),
        .cout     (sum_cout),
        .nib_cout (sum_nib)
    );

    assign pc_inc  = pc + 15'h0001;
    assign ofs_ext = {{6{offset[8]}}, offset};
    assign busy    = (state == ST_NOP);

    // Issue during the forced NOP is the discarded slot
    // Read data must be valid in the issue cycle; no stall for a slow register file
    assign take      = issue && (state == ST_RUN);
    assign shift_res = {reg_rdata[`BAX_MSB], reg_rdata[`BAX_MSB:1]};
    assign clr_res   = reg_rdata & ~(8'h01 << bit_pos);
    assign res_zero  = (next_result == 8'h00);

    always @* begin
        next_result      = reg_rdata;
        next_write       = 1'b0;
        next_flags_add   = 1'b0;
        next_flags_shift = 1'b0;
        next_second      = 1'b0;
        next_pc          = pc_inc;
        next_to_reg      = target_sel;
        case (op)
            `BAX_OP_ADD, `BAX_OP_ADDC: begin
                next_result    = sum;
                next_write     = 1'b1;
                next_flags_add = 1'b1;
            end
            `BAX_OP_ASR: begin
                next_result      = shift_res;
                next_write       = 1'b1;
                next_flags_shift = 1'b1;
            end
            `BAX_OP_BCLR: begin
                next_result = clr_res;
                next_write  = 1'b1;
                // No target select: always back to the register
                next_to_reg = 1'b1;
            end
            `BAX_OP_TSKIP: begin
                next_second = ~reg_rdata[bit_pos];
            end
            `BAX_OP_RJMP: begin
                next_pc     = pc_inc + ofs_ext;
                next_second = 1'b1;
            end
            default: begin
                next_result = reg_rdata;
            end
        endcase
    end

    always @* begin
        case (state)
            ST_RUN:  next_state = (take && next_second) ? ST_NOP : ST_RUN;
            ST_NOP:  next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    // Commit: what this edge changes
    always @* begin
        next_acc       = acc;
        next_ovf       = arith_ovf;
        next_nib       = nibble_carry;
        next_nil       = result_nil;
        next_we        = 1'b0;
        next_waddr     = reg_waddr;
        next_wdata     = reg_wdata;
        next_flush     = 1'b0;
        next_pc_commit = pc;
        if (state == ST_NOP) begin
            // Forced NOP: discarded slot, PC moves past it
            // After a jump this leaves PC at target plus one
            next_pc_commit = pc_inc;
        end else if (take) begin
            next_pc_commit = next_pc;
            next_flush     = next_second;
            if (next_write) begin
                if (next_to_reg == `BAX_TGT_REG) begin
                    next_we    = 1'b1;
                    next_waddr = reg_addr;
                    next_wdata = next_result;
                end else begin
                    next_acc = next_result;
                end
            end
            if (next_flags_add) begin
                next_ovf = sum_cout;
                next_nib = sum_nib;
                next_nil = res_zero;
            end
            if (next_flags_shift) begin
                next_ovf = reg_rdata[0];
                next_nil = res_zero;
            end
        end
    end

    // Every output is a flop; nothing combinational leaves but busy
    always @(posedge clock) begin
        if (sys_rst) begin
            state        <= ST_RUN;
            acc          <= `BAX_ACC_RST;
            arith_ovf    <= 1'b0;
            nibble_carry <= 1'b0;
            result_nil   <= 1'b0;
            pc           <= `BAX_PC_RST;
            reg_we       <= 1'b0;
            reg_waddr    <= 7'h00;
            reg_wdata    <= 8'h00;
            flush        <= 1'b0;
        end else begin
            state        <= next_state;
            acc          <= next_acc;
            arith_ovf    <= next_ovf;
            nibble_carry <= next_nib;
            result_nil   <= next_nil;
            pc           <= next_pc_commit;
            reg_we       <= next_we;
            reg_waddr    <= next_waddr;
            reg_wdata    <= next_wdata;
            flush        <= next_flush;
        end
    end

endmodule

// *** dv/bax_exec_checker.sv ***
`timescale 1ns/10ps
`include "bax_consts.vh"
module bax_exec_checker (
    input wire        clock,
    input wire        sys_rst,
    input wire        issue,
    input wire [2:0]  op,
    input wire [6:0]  reg_addr,
    input wire        target_sel,
    input wire [2:0]  bit_pos,
    input wire [8:0]  offset,
    input wire [7:0]  reg_rdata,
    input wire        reg_we,
    input wire [6:0]  reg_waddr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  acc,
    input wire        arith_ovf,
    input wire        nibble_carry,
    input wire        result_nil,
    input wire [14:0] pc,
    input wire        busy,
    input wire        flush
);
default clocking @(posedge clock); endclocking
default disable iff (sys_rst);
wire tk = issue && !busy;
a_add_acc: assert property ($past(tk && op == `BAX_OP_ADD && !target_sel) |->
    acc == $past(acc + reg_rdata)) else $error("add sum");
a_add_flags: assert property ($past(tk && op == `BAX_OP_ADD) |->
    arith_ovf == $past(acc + reg_rdata > 9'h0ff) && nibble_carry == $past(acc[3:0] + reg_rdata[3:0] > 5'h0f))
    else $error("add carries");
a_nil_flag: assert property ($past(tk && op == `BAX_OP_ADD && !target_sel) |->
    result_nil == (acc == 8'h00)) else $error("nil flag");
a_carry_dest: assert property ($past(tk && op == `BAX_OP_ADDC && target_sel) |-> reg_we &&
    reg_waddr == $past(reg_addr) && reg_wdata == $past(acc + reg_rdata + arith_ovf) && $stable(acc))
    else $error("carry add dest");
a_shift_res: assert property ($past(tk && op == `BAX_OP_ASR && !target_sel) |->
    acc == {$past(reg_rdata[7]), $past(reg_rdata[7:1])} && arith_ovf == $past(reg_rdata[0]) &&
    $stable(nibble_carry)) else $error("shift");
a_clear_bit: assert property ($past(tk && op == `BAX_OP_BCLR) |-> reg_we &&
    reg_wdata == $past(reg_rdata & ~(8'h01 << bit_pos)) && $stable(arith_ovf) && $stable(result_nil))
    else $error("clear bit");
a_skip_nop: assert property ($past(tk && op == `BAX_OP_TSKIP) |->
    (busy != $past(reg_rdata[bit_pos]) && flush == busy) ##1 !(busy && $past(busy))) else $error("skip");
a_jump_pc: assert property ($past(tk && op == `BAX_OP_RJMP) |->
    (pc == $past(pc + 15'h0001 + {{6{offset[8]}}, offset}) && busy && flush) ##1 !busy)
    else $error("jump");
endmodule
bind bax_exec bax_exec_checker u_bax_exec_checker (.*);

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`include "bax_consts.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
reg        clock = 0, sys_rst = 1, issue = 0, target_sel = 0;
reg [2:0]  op = 0, bit_pos = 0;
reg [6:0]  reg_addr = 7'h5a;
reg [8:0]  offset = 0;
reg [7:0]  reg_rdata = 0;
reg [14:0] p;
reg [7:0]  a0;
wire       reg_we, arith_ovf, nibble_carry, result_nil, busy, flush;
wire [6:0] reg_waddr;
wire [7:0] reg_wdata, acc;
wire [14:0] pc;
int n_mismatch = 0, checks_done = 0, cyc = 0;
bax_exec u_bax_exec (.*);
always #50 clock = ~clock;
// Whole run needs well under a hundred cycles
always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
        n_mismatch++;
        summarize;
    end
end
task run(input [2:0] o, input [7:0] d, input t, input [2:0] b, input [8:0] k);
    @(posedge clock);
    {op, reg_rdata, target_sel, bit_pos, offset, issue} <= {o, d, t, b, k, 1'b1};
    @(posedge clock);
    issue <= 0;
    #1;
endtask
task t_arith;
    run(`BAX_OP_ADD, 8'h8f, 0, 0, 0);
    `CHK("acc", 8'h8f, acc)
    run(`BAX_OP_ADD, 8'h71, 0, 0, 0);
    `CHK("flags", 11'h007, {acc, arith_ovf, nibble_carry, result_nil})
    run(`BAX_OP_ADDC, 8'h05, 1, 0, 0);
    `CHK("wb", 24'h015a06, {7'h00, reg_we, 1'b0, reg_waddr, reg_wdata})
    `CHK("acc", 8'h00, acc)
    run(`BAX_OP_ASR, 8'h81, 0, 0, 0);
    `CHK("asr", 10'h302, {acc, arith_ovf, result_nil})
    run(`BAX_OP_BCLR, 8'hff, 1, 7, 0);
    `CHK("clr", 10'h2ff, {reg_we, reg_wdata, arith_ovf})
endtask
task t_skip;
    p = pc;
    run(`BAX_OP_TSKIP, 8'h10, 0, 4, 0);
    `CHK("noskip", {1'b0, p + 15'h0001}, {busy, pc})
    run(`BAX_OP_TSKIP, 8'h10, 0, 3, 0);
    `CHK("skip", 2'b11, {busy, flush})
    @(posedge clock);
    #1;
    `CHK("nop end", 1'b0, busy)
endtask
task t_jump(input [8:0] k);
    p = pc;
    run(`BAX_OP_RJMP, 0, 0, 0, k);
    `CHK("pc", p + 15'h0001 + {{6{k[8]}}, k}, pc)
    `CHK("flush", 2'b11, {busy, flush})
    @(posedge clock);
    #1;
    `CHK("2cyc", 1'b0, busy)
endtask
task t_dest;
    @(posedge clock);
    reg_addr <= 7'h7f;
    run(`BAX_OP_ADD, 8'h40, 1, 0, 0);
    `CHK("add wb", 18'h2_0181, {reg_we, reg_wdata, acc, result_nil})
    run(`BAX_OP_ADDC, 8'h0f, 0, 0, 0);
    `CHK("addc acc", 11'h682, {acc, arith_ovf, nibble_carry, result_nil})
    run(`BAX_OP_ASR, 8'h03, 1, 0, 0);
    `CHK("asr wb", 19'h4_0743, {reg_we, reg_wdata, acc, arith_ovf, nibble_carry})
    run(`BAX_OP_BCLR, 8'h0f, 0, 2, 0);
    `CHK("clr dest", 24'hff_0bd0, {reg_we, reg_waddr, reg_wdata, acc})
    `CHK("clr flags", 3'h6, {arith_ovf, nibble_carry, result_nil})
endtask
task t_refuse;
    p = pc;
    a0 = acc;
    @(posedge clock);
    {op, offset, issue} <= {`BAX_OP_RJMP, 9'h004, 1'b1};
    @(posedge clock);
    // Issue held into the forced NOP slot
    {op, reg_rdata, target_sel} <= {`BAX_OP_ADD, 8'h33, 1'b0};
    @(posedge clock);
    issue <= 0;
    #1;
    `CHK("refused", {1'b0, a0}, {reg_we, acc})
    `CHK("nop pc", p + 15'h0006, pc)
endtask
task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    t_arith;
    t_dest;
    t_skip;
    t_jump(9'h100);
    t_jump(9'h0ff);
    t_refuse;
    summarize;
end
endmodule
